// [hw/rfedac_map.svh]
`ifndef RFEDAC_MAP_SVH
`define RFEDAC_MAP_SVH
`define RFEDAC_DI_BIT      0
`define RFEDAC_TE_BIT      1
`define RFEDAC_TCB_LSB     2
`define RFEDAC_TCB_MSB     8
`define RFEDAC_CNT_LSB     9
`define RFEDAC_CNT_MSB     11
`define RFEDAC_CNT_MAX     3'h7
`define RFEDAC_DI_RST      1'h0
`define RFEDAC_TE_RST      1'h0
`define RFEDAC_WIN_NUM     8
`define RFEDAC_OUTS_BASE   5'h08
`define RFEDAC_LOCALS_BASE 5'h10
`define RFEDAC_INS_BASE    5'h18
`define RFEDAC_LOC_PC      3'h1
`define RFEDAC_LOC_NPC     3'h2
`endif

// [hw/rfedac_pkg.sv]
package rfedac_pkg;
  typedef logic [6:0] rfedac_chk_t;
  typedef enum logic [1:0] {
    RFEDAC_ERR_NONE,
    RFEDAC_ERR_SINGLE,
    RFEDAC_ERR_DOUBLE
  } rfedac_err_t;
endpackage

// [hw/rfedac_top.sv]
`timescale 1ns/100ps
`include "rfedac_map.svh"
module rfedac_top #(
  parameter int NWIN = `RFEDAC_WIN_NUM
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [2:0]  CWP_I,
  input  wire logic [4:0]  RD_ADDR_I,
  input  wire logic        RD_EN_I,
  output logic      [31:0] RD_DATA_O,
  output logic             RD_VALID_O,
  output logic             RD_DERR_O,
  input  wire logic [4:0]  WR_ADDR_I,
  input  wire logic        WR_EN_I,
  input  wire logic [31:0] WR_DATA_I,
  input  wire logic        TRAP_I,
  input  wire logic [31:0] PC_I,
  input  wire logic [31:0] NPC_I,
  input  wire logic        ASR_WR_I,
  input  wire logic [31:0] ASR_WDATA_I,
  output logic      [31:0] ASR_RDATA_O
);
  localparam int NPHYS = 8 + 16 * NWIN;
  localparam int PW    = $clog2(NPHYS);

  logic rst_s1_q, rst_n_q;
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Hamming(38,32) plus overall parity: 7 check bits
  function automatic logic [5:0] ham_syn(input logic [31:0] d, input logic [5:0] c);
    logic [5:0] s;
    int         p;
    int         k;
    s = c;
    k = 0;
    for (p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int b = 0; b < 6; b++) begin
          if (p[b]) s[b] = s[b] ^ d[k];
        end
        k++;
      end
    end
    return s;
  endfunction

  function automatic rfedac_pkg::rfedac_chk_t chk_gen(input logic [31:0] d);
    logic [5:0] h;
    h = ham_syn(d, 6'h00);
    return {^{d, h}, h};
  endfunction

  function automatic logic [31:0] flip_mask(input logic [5:0] s);
    logic [31:0] m;
    int          p;
    int          k;
    m = 32'h0000_0000;
    k = 0;
    for (p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (s == p[5:0]) m[k] = 1'b1;
        k++;
      end
    end
    return m;
  endfunction

  // Window-relative to physical index; ins of window w are outs of w+1
  function automatic logic [PW-1:0] phys(input logic [2:0] cwp, input logic [4:0] r);
    logic [31:0] w;
    w = 32'(cwp);
    if (r < `RFEDAC_OUTS_BASE) return PW'(r);
    if (r < `RFEDAC_LOCALS_BASE) return PW'(8 + 16 * w + 32'(r) - 8);
    if (r < `RFEDAC_INS_BASE) return PW'(8 + 16 * w + 32'(r) - 8);
    return PW'(8 + 16 * ((w + 1) % NWIN) + 32'(r) - 24);
  endfunction

  logic       di_q, te_q;
  logic [2:0] cnt_q;
  logic [6:0] tcb_q;
  logic       corr;

  always_ff @(posedge CORE_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      di_q <= `RFEDAC_DI_RST;
      te_q <= `RFEDAC_TE_RST;
    end else if (ASR_WR_I) begin
      di_q <= ASR_WDATA_I[`RFEDAC_DI_BIT];
      te_q <= ASR_WDATA_I[`RFEDAC_TE_BIT];
    end
  end

  // No reset: left undetermined until written
  always_ff @(posedge CORE_CLK_I) begin
    if (ASR_WR_I) begin
      tcb_q <= ASR_WDATA_I[`RFEDAC_TCB_MSB:`RFEDAC_TCB_LSB];
      cnt_q <= ASR_WDATA_I[`RFEDAC_CNT_MSB:`RFEDAC_CNT_LSB];
    end else if (corr && cnt_q != `RFEDAC_CNT_MAX) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Reserved upper bits read as zero
  assign ASR_RDATA_O = {20'h00000, cnt_q, tcb_q, te_q, di_q};

  // Storage deliberately has no reset
  logic [38:0] mem [NPHYS];
  logic [PW-1:0] wa;
  logic [31:0]   wd;
  logic          we;
  always_comb begin
    wa = phys(CWP_I, WR_ADDR_I);
    wd = WR_DATA_I;
    we = WR_EN_I && WR_ADDR_I != 5'h00;
    // Trap wins over a plain write in the same cycle
    if (TRAP_I) begin
      wa = phys(CWP_I, `RFEDAC_LOCALS_BASE + 5'(`RFEDAC_LOC_PC));
      wd = PC_I;
      we = 1'b1;
    end
  end

  logic [PW-1:0] npc_a;
  assign npc_a = phys(CWP_I, `RFEDAC_LOCALS_BASE + 5'(`RFEDAC_LOC_NPC));

  always_ff @(posedge CORE_CLK_I) begin
    // Trap stores two locals at once, hence a second write port
    if (we) begin
      mem[wa] <= {chk_gen(wd) ^ (te_q ? tcb_q : 7'h00), wd};
    end
    if (TRAP_I) begin
      mem[npc_a] <= {chk_gen(NPC_I) ^ (te_q ? tcb_q : 7'h00), NPC_I};
    end
  end

  logic [38:0] rw;
  logic [5:0]  syn;
  logic        par;
  rfedac_pkg::rfedac_err_t err;
  assign rw  = mem[phys(CWP_I, RD_ADDR_I)];
  assign syn = ham_syn(rw[31:0], rw[37:32]);
  assign par = ^rw;
  // Register 0 is never checked: its stored word is meaningless
  always_comb begin
    err = rfedac_pkg::RFEDAC_ERR_NONE;
    if (!di_q && RD_ADDR_I != 5'h00) begin
      if (par) err = rfedac_pkg::RFEDAC_ERR_SINGLE;
      else if (syn != 6'h00) err = rfedac_pkg::RFEDAC_ERR_DOUBLE;
    end
  end
  // Only corrected reads count; double errors are flagged instead
  assign corr = RD_EN_I && err == rfedac_pkg::RFEDAC_ERR_SINGLE;

  always_ff @(posedge CORE_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      RD_DATA_O  <= 32'h0000_0000;
      RD_VALID_O <= 1'b0;
      RD_DERR_O  <= 1'b0;
    end else begin
      RD_VALID_O <= RD_EN_I;
      RD_DERR_O  <= RD_EN_I && err == rfedac_pkg::RFEDAC_ERR_DOUBLE;
      if (RD_EN_I) begin
        if (RD_ADDR_I == 5'h00) RD_DATA_O <= 32'h0000_0000;
        else if (err == rfedac_pkg::RFEDAC_ERR_SINGLE) RD_DATA_O <= rw[31:0] ^ flip_mask(syn);
        else RD_DATA_O <= rw[31:0];
      end
    end
  end

  cnt_sat_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n_q)
    (cnt_q == 3'h7 && !ASR_WR_I) |=> cnt_q == 3'h7) else $error("counter left saturation");
  cnt_inc_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n_q)
    (corr && !ASR_WR_I && cnt_q != 3'h7) |=> cnt_q == $past(cnt_q) + 3'h1) else $error("counter missed correction");
  zero_read_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n_q)
    (RD_EN_I && RD_ADDR_I == 5'h00) |=> RD_VALID_O && RD_DATA_O == 32'h0 && !RD_DERR_O)
    else $error("zero register nonzero");
  chk_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n_q)
    (di_q && RD_EN_I) |=> !RD_DERR_O) else $error("error flagged while checking off");
  ctl_wr_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n_q)
    ASR_WR_I |=> ASR_RDATA_O[11:0] == $past(ASR_WDATA_I[11:0])) else $error("control write lost");
  inj_en_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n_q)
    ASR_WR_I |=> te_q == $past(ASR_WDATA_I[1])) else $error("injection enable wrong");
  ctl_rst_a: assert property (@(posedge CORE_CLK_I)
    $rose(rst_n_q) |-> !te_q && !di_q) else $error("control not cleared by reset");
  rd_valid_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n_q)
    RD_DERR_O |-> RD_VALID_O) else $error("error flag without read");
  // Stored check bits, with and without injected corruption
  inj_store_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n_q)
    (we && te_q) |=> mem[$past(wa)][38:32] == (chk_gen($past(wd)) ^ $past(tcb_q)))
    else $error("injected check bits wrong");
  plain_store_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n_q)
    (we && !te_q) |=> mem[$past(wa)][38:32] == chk_gen($past(wd)))
    else $error("check bits corrupted without injection");
  trap_save_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n_q)
    TRAP_I |=> mem[$past(wa)][31:0] == $past(PC_I) && mem[$past(npc_a)][31:0] == $past(NPC_I))
    else $error("trap state not saved");
  dbl_flag_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n_q)
    (RD_EN_I && !di_q && RD_ADDR_I != 5'h00 && !par && syn != 6'h00) |=> RD_DERR_O)
    else $error("double error not flagged");
  sgl_fix_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n_q)
    (RD_EN_I && par) |=> !RD_DERR_O)
    else $error("single error flagged as double");
endmodule // rfedac_top

// [test/rfedac_iu.sv]
`timescale 1ns/100ps
module rfedac_iu (
  input  wire logic        clk_i,
  output logic      [2:0]  cwp_o,
  output logic      [4:0]  ra_o,
  output logic             re_o,
  output logic      [4:0]  wa_o,
  output logic             we_o,
  output logic      [31:0] wd_o,
  output logic             tr_o,
  output logic      [31:0] pc_o,
  output logic      [31:0] np_o,
  output logic             aw_o,
  output logic      [31:0] ad_o
);
  initial {cwp_o, ra_o, re_o, wa_o, we_o, wd_o, tr_o, pc_o, np_o, aw_o, ad_o} = '0;
  // Released wd_o and ad_o data lines turn over; the trap pc_o and np_o lines hold
  task automatic fin;
    @(posedge clk_i) #1;
    {re_o, we_o, tr_o, aw_o} = '0;
    {wd_o, ad_o} = ~{wd_o, ad_o};
  endtask
  task automatic rd(input logic [2:0] w, input logic [4:0] a);
    @(posedge clk_i) #1;
    {cwp_o, ra_o, re_o} = {w, a, 1'b1};
    fin;
  endtask
  task automatic wr(input logic [2:0] w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i) #1;
    {cwp_o, wa_o, wd_o, we_o} = {w, a, d, 1'b1};
    fin;
  endtask
  task automatic asr(input logic [31:0] d);
    @(posedge clk_i) #1;
    {ad_o, aw_o} = {d, 1'b1};
    fin;
  endtask
  task automatic trap(input logic [2:0] w, input logic [31:0] p, input logic [31:0] n);
    @(posedge clk_i) #1;
    {cwp_o, pc_o, np_o, tr_o} = {w, p, n, 1'b1};
    fin;
  endtask
endmodule // rfedac_iu

// [test/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic        clk;
  logic        nrst;
  logic [2:0]  cwp;
  logic [4:0]  ra, wa;
  logic        re, we, tr, aw, vld, derr;
  logic [31:0] wd, pc, np, ad, rdat, ctl;
  int          n_fail = 0;
  int          checked = 0;
  rfedac_top rfedac_top_inst (.CORE_CLK_I(clk), .NRST_I(nrst), .CWP_I(cwp), .RD_ADDR_I(ra), .RD_EN_I(re),
    .RD_DATA_O(rdat), .RD_VALID_O(vld), .RD_DERR_O(derr), .WR_ADDR_I(wa), .WR_EN_I(we), .WR_DATA_I(wd),
    .TRAP_I(tr), .PC_I(pc), .NPC_I(np), .ASR_WR_I(aw), .ASR_WDATA_I(ad), .ASR_RDATA_O(ctl));
  rfedac_iu rfedac_iu_inst (.clk_i(clk), .cwp_o(cwp), .ra_o(ra), .re_o(re), .wa_o(wa), .we_o(we), .wd_o(wd),
    .tr_o(tr), .pc_o(pc), .np_o(np), .aw_o(aw), .ad_o(ad));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rdc(input logic [2:0] w, input logic [4:0] a, input logic [31:0] d, input logic e);
    rfedac_iu_inst.rd(w, a);
    chk("valid", 32'h1, {31'h0, vld});
    chk("derr", {31'h0, e}, {31'h0, derr});
    if (!e) chk("data", d, rdat);
  endtask
  task automatic t_ctl;
    chk("ctl rst", 32'h0, ctl & 32'h3);
    rfedac_iu_inst.asr(32'hffffffff);
    chk("ctl", 32'hfff, ctl);
    $display("ctl test end");
  endtask
  task automatic t_map;
    rfedac_iu_inst.wr(3'h0, 5'h0, 32'ha5);
    rdc(3'h0, 5'h0, 32'h0, 1'b0);
    rfedac_iu_inst.wr(3'h1, 5'h8, 32'hb1);
    rdc(3'h0, 5'h18, 32'hb1, 1'b0);
    rfedac_iu_inst.trap(3'h4, 32'h100, 32'h104);
    rdc(3'h4, 5'h11, 32'h100, 1'b0);
    rdc(3'h4, 5'h12, 32'h104, 1'b0);
    rfedac_iu_inst.wr(3'h0, 5'h8, 32'hb7);
    rdc(3'h7, 5'h18, 32'hb7, 1'b0);
    rfedac_iu_inst.trap(3'h7, 32'h2000, 32'h2004);
    rdc(3'h7, 5'h11, 32'h2000, 1'b0);
    rdc(3'h7, 5'h12, 32'h2004, 1'b0);
    $display("map test end");
  endtask
  task automatic t_edac;
    rfedac_iu_inst.asr(32'h6);
    for (int i = 1; i < 4; i++) rfedac_iu_inst.wr(3'h0, 5'(i), 32'hc0 + i);
    rfedac_iu_inst.asr(32'he);
    rfedac_iu_inst.wr(3'h0, 5'h6, 32'hd6);
    rfedac_iu_inst.asr(32'h0);
    rdc(3'h0, 5'h1, 32'hc1, 1'b0);
    chk("cnt", 32'h200, ctl);
    rfedac_iu_inst.asr(32'hc00);
    rdc(3'h0, 5'h2, 32'hc2, 1'b0);
    rdc(3'h0, 5'h3, 32'hc3, 1'b0);
    chk("cnt sat", 32'he00, ctl);
    rdc(3'h0, 5'h6, 32'h0, 1'b1);
    rfedac_iu_inst.asr(32'h1);
    rdc(3'h0, 5'h6, 32'hd6, 1'b0);
    rfedac_iu_inst.asr(32'h0);
    rfedac_iu_inst.wr(3'h0, 5'h7, 32'he7);
    rdc(3'h0, 5'h7, 32'he7, 1'b0);
    chk("cnt clean", 32'h0, ctl);
    $display("edac test end");
  endtask
  task automatic t_rst;
    rfedac_iu_inst.asr(32'h3);
    chk("ctl set", 32'h3, ctl & 32'h3);
    @(posedge clk);
    #1 nrst = 1'b0;
    @(posedge clk);
    chk("valid rst", 32'h0, {31'h0, vld});
    chk("data rst", 32'h0, rdat);
    chk("ctl rst mid", 32'h0, ctl & 32'h3);
    #1 nrst = 1'b1;
    repeat (2) @(posedge clk);
    chk("ctl rst hold", 32'h0, ctl & 32'h3);
    $display("reset test end");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    t_ctl();
    t_map();
    t_rst();
    t_edac();
    stop_test();
  end
endmodule // tb_top
